// File: src/issr_readback.sv
// Interrupt source status readback with AXI4-Lite slave
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module issr_readback import issr_pkg::*; (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic hw_watchdog_req,
    input wire logic nonmaskable_pin,
    input wire logic abnormal_frequency_detect,
    input wire logic soft_watchdog_req,
    input wire logic low_voltage_detector,
    input wire logic [3:0] waveform_req,
    input wire logic [6:0] ext_pin_req,
    input wire logic ext_pin15_req,
    input wire logic [7:0] serial_rx_req,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic nmi_vector_req,
    output logic [ISSR_LINES-1:0] line_vector_req,
    output logic irq
);
    logic [31:0] stat_nxt [ISSR_LINES];
    logic [31:0] nmi_nxt;
    logic [31:0] stat_r [ISSR_LINES];
    logic [31:0] nmi_r;
    logic [ISSR_LINES-1:0] req_nxt;
    logic [ISSR_LINES-1:0] evt_r;
    logic [ISSR_LINES-1:0] mask_r;
    logic [ISSR_LINES-1:0] prev_r;
    logic aw_got_r;
    logic w_got_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic rd_stat_clr;
    logic [31:0] rd_word;
    logic rd_ok;
    logic [4:0] line_idx;

    // Source mapping; unused lines stay zero
    always_comb begin
        nmi_nxt = ISSR_ZERO;
        nmi_nxt[ISSR_HWWD_BIT] = hw_watchdog_req;
        nmi_nxt[ISSR_NMI_BIT] = nonmaskable_pin;
        for (int i = 0; i < ISSR_LINES; i++) begin
            stat_nxt[i] = ISSR_ZERO;
        end
        stat_nxt[0][0] = abnormal_frequency_detect;
        stat_nxt[1][0] = soft_watchdog_req;
        stat_nxt[2][0] = low_voltage_detector;
        stat_nxt[3][ISSR_WAVE_W-1:0] = waveform_req;
        stat_nxt[4][ISSR_EXT_W-1:0] = ext_pin_req;
        stat_nxt[5][ISSR_PIN15_BIT] = ext_pin15_req;
        for (int c = 0; c < ISSR_SER_CH; c++) begin
            stat_nxt[6 + 2 * c][0] = serial_rx_req[c];
        end
    end

    // Per-line OR feeds the vector controller
    genvar g;
    generate
        for (g = 0; g < ISSR_LINES; g++) begin : g_line
            assign req_nxt[g] = |stat_nxt[g];
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            nmi_r <= ISSR_ZERO;
            for (int i = 0; i < ISSR_LINES; i++) begin
                stat_r[i] <= ISSR_ZERO;
            end
            nmi_vector_req <= 1'b0;
            line_vector_req <= '0;
        end else begin
            nmi_r <= nmi_nxt;
            for (int i = 0; i < ISSR_LINES; i++) begin
                stat_r[i] <= stat_nxt[i];
            end
            nmi_vector_req <= |nmi_nxt;
            line_vector_req <= req_nxt;
        end
    end

    // Rising line request sets a sticky event; set beats read clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prev_r <= '0;
            evt_r <= '0;
            irq <= 1'b0;
        end else begin
            prev_r <= req_nxt;
            evt_r <= (rd_stat_clr ? '0 : evt_r) | (req_nxt & ~prev_r);
            irq <= |(((rd_stat_clr ? '0 : evt_r) | (req_nxt & ~prev_r)) & mask_r);
        end
    end

    // Read decode; byte address selects word, 0x84-0xD4 read lines 0-20 again (mask not readable), misaligned or other is error
    assign line_idx = 5'((s_axi_araddr - ISSR_LINE_BASE) >> 2);
    always_comb begin
        rd_word = ISSR_ZERO;
        rd_ok = 1'b1;
        if (s_axi_araddr[1:0] != 2'h0) begin
            rd_ok = 1'b0;
        end else if (s_axi_araddr == ISSR_NMI_OFS) begin
            rd_word = nmi_r;
        end else if (s_axi_araddr >= ISSR_LINE_BASE &&
                     line_idx < 5'(ISSR_LINES)) begin
            rd_word = stat_r[line_idx];
        end else if (s_axi_araddr == ISSR_EVT_STAT_OFS) begin
            rd_word = {11'h000, evt_r};
        end else if (s_axi_araddr == ISSR_EVT_MASK_OFS) begin
            rd_word = {11'h000, mask_r};
        end else begin
            rd_ok = 1'b0;
        end
    end
    assign rd_stat_clr = s_axi_arvalid && s_axi_arready &&
                         s_axi_araddr == ISSR_EVT_STAT_OFS;

    // Read channel: one read at a time, answer one cycle after address
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= ISSR_ZERO;
            s_axi_rresp <= ISSR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? ISSR_RESP_OKAY : ISSR_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Write channel: address and data in either order
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= ISSR_ZERO;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ISSR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                // Status words are read only; only the mask takes a write
                s_axi_bresp <= (awaddr_r == ISSR_EVT_MASK_OFS) ?
                               ISSR_RESP_OKAY : ISSR_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Mask register; any nonzero strobe writes the whole word, for simplicity
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mask_r <= '0;
        end else if (aw_got_r && w_got_r && !s_axi_bvalid &&
                     awaddr_r == ISSR_EVT_MASK_OFS && s_axi_wstrb != 4'h0) begin
            mask_r <= wdata_r[ISSR_LINES-1:0];
        end
    end
endmodule

// File: src/issr_pkg.sv
// Constants for the interrupt source status readback block
// Notes on behaviour
// - Exception status: watchdog bit1, pin bit0
// - Exception bit0 set while nonmaskable pin pending
// - Unassigned status bits always read zero
// - Line 0 bit0 shows clock supervisor fault
// - Line 1 bit0 shows soft watchdog request
// - Line 2 bit0 shows low voltage request
// - Line 3 bits 3:0 motor timer requests
// - Line 4 bits 6:0 external pins 0-6
// - Line 5 bit7 external pin 15 only
// - Even lines 6-20 bit0 serial receive 0-7
// - Exception is vector 2, line n 16+n
// - Vector request is OR of shown sources
// - Readback only for vector 2, 16-36
package issr_pkg;
    localparam int ISSR_AW = 8;
    localparam logic [7:0] ISSR_NMI_OFS = 8'h00;
    localparam logic [7:0] ISSR_LINE_BASE = 8'h04;
    localparam logic [7:0] ISSR_EVT_STAT_OFS = 8'h80;
    localparam logic [7:0] ISSR_EVT_MASK_OFS = 8'h84;
    localparam int ISSR_LINES = 21;
    localparam int ISSR_SER_CH = 8;
    localparam int ISSR_EXC_VECTOR = 2;
    localparam int ISSR_LINE_VECTOR_BASE = 16;
    localparam int ISSR_HWWD_BIT = 1;
    localparam int ISSR_NMI_BIT = 0;
    localparam int ISSR_PIN15_BIT = 7;
    localparam int ISSR_WAVE_W = 4;
    localparam int ISSR_EXT_W = 7;
    localparam logic [1:0] ISSR_RESP_OKAY = 2'h0;
    localparam logic [1:0] ISSR_RESP_SLVERR = 2'h2;
    localparam logic [31:0] ISSR_ZERO = 32'h0000_0000;
endpackage

// File: test/issr_src_model.sv
// Level request sources on the far side of the readback block
`timescale 1ns/1ps
module issr_src_model (
    input wire logic mclk,
    input wire logic [24:0] want,
    output logic [24:0] src
);
    // Changes only after an edge, as registered peripherals do
    always_ff @(posedge mclk) begin
        src <= want;
    end
endmodule

// File: test/issr_readback_properties.sv
// Concurrent checks on the readback block ports
`timescale 1ns/1ps
module issr_readback_properties import issr_pkg::*; (
    input wire logic mclk, sys_rst, hw_watchdog_req, nonmaskable_pin, abnormal_frequency_detect,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, nmi_vector_req,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [ISSR_LINES-1:0] line_vector_req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire logic nmi_or = hw_watchdog_req | nonmaskable_pin;
    // Only steady sources judged, so one or two cycles of lag both pass
    chk_nmi_vector_or: assert property ($past(nmi_or) == $past(nmi_or, 2) |->
        nmi_vector_req == $past(nmi_or)) else $error("nmi vector wrong");
    chk_line0_vector: assert property ($past(abnormal_frequency_detect) ==
        $past(abnormal_frequency_detect, 2) |-> line_vector_req[0] ==
        $past(abnormal_frequency_detect)) else $error("line 0 vector wrong");
    chk_odd_lines_idle: assert property ((line_vector_req & 21'h0AAA80) == 21'h000000)
        else $error("odd line vector set");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > 8'h84 |=> s_axi_rdata == ISSR_ZERO && s_axi_rresp == ISSR_RESP_SLVERR)
        else $error("unmapped read not refused");
    chk_status_read_ok: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr < 8'h58 && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == ISSR_RESP_OKAY)
        else $error("status read refused");
endmodule
bind issr_readback issr_readback_properties chk (.*);

// File: test/testbench.sv
// Self-checking bench for the status readback block
`timescale 1ns/1ps
module testbench import issr_pkg::*;;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [24:0] want = '0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    wire logic [24:0] src;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic irq, nmi_vector_req;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [ISSR_LINES-1:0] line_vector_req;
    int miscompares = 0;
    int total_checks = 0;
    issr_src_model src_m (.mclk(mclk), .want(want), .src(src));
    issr_readback DUT (.*, .hw_watchdog_req(src[1]), .nonmaskable_pin(src[0]),
        .abnormal_frequency_detect(src[2]), .soft_watchdog_req(src[3]),
        .low_voltage_detector(src[4]), .waveform_req(src[8:5]), .ext_pin_req(src[15:9]),
        .ext_pin15_req(src[16]), .serial_rx_req(src[24:17]));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t %s", $time, m);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, d, "read data");
        chk(32'(s_axi_rresp), 32'(r), "read response");
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bit ad = 1'b0;
        bit wd = 1'b0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end while (!(ad && wd));
        do @(posedge mclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(r), "write response");
    endtask
    task automatic t_map;
        logic [7:0] a;
        for (int i = 0; i < 25; i++) begin
            want <= 25'h1 << i;
            a = i < 2 ? 8'h00 : i < 5 ? 8'(4 * i - 4) : i < 9 ? 8'h10 : i < 16 ? 8'h14
                : i < 17 ? 8'h18 : 8'(8 * i - 108);
            repeat (3) @(posedge mclk);
            rd(a, i < 2 ? 32'h1 << i : i < 5 ? 32'h1 : i < 9 ? 32'h1 << (i - 5)
                : i < 16 ? 32'h1 << (i - 9) : i < 17 ? 32'h80 : 32'h1, ISSR_RESP_OKAY);
            chk(32'(line_vector_req), a == 8'h00 ? 32'h0 : 32'h1 << (a / 4 - 1), "vector");
        end
        $display("map done");
    endtask
    task automatic t_ro;
        want <= 25'h1E0;
        wr(8'h10, ISSR_ZERO, ISSR_RESP_SLVERR);
        rd(8'h10, 32'hF, ISSR_RESP_OKAY);
        rd(8'h10, 32'hF, ISSR_RESP_OKAY);
        rd(8'h20, ISSR_ZERO, ISSR_RESP_OKAY);
        rd(8'hFC, ISSR_ZERO, ISSR_RESP_SLVERR);
        $display("read-only done");
    endtask
    task automatic t_irq;
        rd(ISSR_EVT_MASK_OFS, ISSR_ZERO, ISSR_RESP_OKAY);
        rd(ISSR_EVT_STAT_OFS, 32'h15557F, ISSR_RESP_OKAY);
        wr(ISSR_EVT_MASK_OFS, 32'h10, ISSR_RESP_OKAY);
        want <= 25'h200;
        repeat (6) @(posedge mclk);
        chk(32'(irq), 32'h1, "irq raise");
        rd(ISSR_EVT_STAT_OFS, 32'h10, ISSR_RESP_OKAY);
        want <= 25'h4;
        repeat (6) @(posedge mclk);
        // Line 0 event is masked, so the output stays low
        chk(32'(irq), 32'h0, "irq masked");
        rd(ISSR_EVT_STAT_OFS, 32'h1, ISSR_RESP_OKAY);
        $display("irq done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        forever #5 mclk = ~mclk;
    end
    initial begin
        #50us;
        miscompares++;
        $display("mismatch t=%0t watchdog", $time);
        close_out;
    end
    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        t_map;
        t_ro;
        t_irq;
        close_out;
    end
endmodule
